// *** hdl/ppc_profile_position.sv ***
// Profile-position command and status handling for a servo drive.
// Assumes a trajectory generator outside that reports done, halt and fault.
//
// Functional notes
// RL1 - Written parameters take effect with no confirmation
// RL2 - Moves start only when operation enabled
// RL3 - Control bit 6 picks absolute or relative
// RL4 - Master homes before first absolute move
// RL5 - Bit 4 rising starts or queues move
// RL6 - Bit 5 clear buffers set until target
// RL7 - Newer pending set replaces older one
// RL8 - Bit 5 set switches target immediately
// RL9 - Status bit 12 acknowledges accepted target
// RL10 - Bit 14 move ended, bit 13 error
// RL11 - Bit 10 set only on reached target
// RL12 - Bit 15 shows valid reference point
// RL13 - Relative base: previous target or actual
// RL14 - Option blocks absolute moves before homing
// RL15 - Setpoint speed unsigned, min one, clamped
// RL16 - Target signed 32-bit user units
// RL17 - Digital input may also start move
// RL18 - Start seen by comparing bit 4 history
`timescale 1ns/10ps
module ppc_profile_position (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Parameter access port
	input  wire logic              reg_wr,
	input  wire logic [15:0]       reg_addr,
	input  wire logic [31:0]       reg_wdata,
	output logic [31:0]            reg_rdata,
	// Drive state and references
	input  wire logic              op_enabled,
	input  wire logic              homed,
	input  wire logic              start_input,
	input  wire logic              software_limit_on,
	input  wire logic signed [31:0] limit_pos_max,
	input  wire logic signed [31:0] limit_pos_min,
	input  wire logic [31:0]       profile_speed_limit,
	input  wire logic signed [31:0] actual_position,
	// Trajectory generator
	input  wire logic              move_done,
	input  wire logic              move_halted,
	input  wire logic              move_fault,
	output ppc_pkg::ppc_set_t      move_set,
	output logic                   move_load
);
	logic [15:0]        homing_required_option_q;
	logic [15:0]        relative_base_option_q;
	logic signed [31:0] move_target_position_q;
	logic [31:0]        move_setpoint_speed_q;
	logic [31:0]        accel_ramp_q;
	logic [31:0]        decel_ramp_q;
	logic [15:0]        drive_control_word_q;
	logic [15:0]        drive_status_word;
	ppc_pkg::ppc_state_t state_q;
	ppc_pkg::ppc_set_t  pend_q;
	ppc_pkg::ppc_set_t  cand;
	ppc_pkg::ppc_set_t  move_set_q;
	logic               move_load_q;
	logic signed [31:0] prev_target_q;
	logic               ack_q;
	logic               end_q;
	logic               reached_q;
	logic               err_q;
	logic               bit_rise;
	logic               start_rise;
	logic               start_req;
	logic               kill;
	logic               abs_blocked;
	logic               immediate;
	logic [31:0]        speed_eff;
	logic signed [31:0] base_pos;
	logic signed [31:0] tgt_raw;
	logic signed [31:0] tgt_eff;

	// Parameter writes act at once
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			homing_required_option_q <= ppc_pkg::RST_HOMING_REQUIRED;
			relative_base_option_q   <= ppc_pkg::RST_RELATIVE_BASE;
			move_target_position_q   <= ppc_pkg::RST_TARGET_POSITION;
			move_setpoint_speed_q    <= ppc_pkg::RST_SETPOINT_SPEED;
			accel_ramp_q             <= ppc_pkg::RST_ACCEL_RAMP;
			decel_ramp_q             <= ppc_pkg::RST_DECEL_RAMP;
			drive_control_word_q     <= ppc_pkg::RST_CONTROL_WORD;
		end else if (reg_wr) begin // [RL1]
			case (reg_addr)
				ppc_pkg::ADDR_HOMING_REQUIRED: begin
					homing_required_option_q <= reg_wdata[15:0];
				end
				ppc_pkg::ADDR_RELATIVE_BASE: begin
					relative_base_option_q <= reg_wdata[15:0];
				end
				ppc_pkg::ADDR_TARGET_POSITION: begin
					move_target_position_q <= reg_wdata; // [RL16]
				end
				ppc_pkg::ADDR_SETPOINT_SPEED: begin
					if (reg_wdata >= ppc_pkg::MIN_SETPOINT_SPEED) begin // [RL15]
						move_setpoint_speed_q <= reg_wdata;
					end
				end
				ppc_pkg::ADDR_ACCEL_RAMP: begin
					accel_ramp_q <= reg_wdata;
				end
				ppc_pkg::ADDR_DECEL_RAMP: begin
					decel_ramp_q <= reg_wdata;
				end
				ppc_pkg::ADDR_CONTROL_WORD: begin
					drive_control_word_q <= reg_wdata[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Start edge from control bit 4
	ppc_edge_detect u_edge (
		.clk   (clk),
		.rst_n (rst_n),
		.level (drive_control_word_q[ppc_pkg::CTL_NEW_SETPOINT]),
		.rise  (bit_rise)
	); // [RL5] [RL18]

	// Start from the configured digital input
	ppc_edge_detect u_edge_in (
		.clk   (clk),
		.rst_n (rst_n),
		.level (start_input),
		.rise  (start_rise)
	); // [RL17]

	assign immediate   = drive_control_word_q[ppc_pkg::CTL_IMMEDIATE];
	// Absolute moves before homing rejected when the option asks for it
	assign abs_blocked = ~drive_control_word_q[ppc_pkg::CTL_RELATIVE]
		& (homing_required_option_q != 16'h0000) & ~homed; // [RL14] [RL4]
	assign start_req   = (bit_rise | start_rise) & op_enabled & ~abs_blocked; // [RL2]
	// A running move is dropped on halt, fault or loss of operation enabled
	assign kill        = (state_q != ppc_pkg::ST_IDLE) & (!op_enabled | move_fault | move_halted);

	// Speed clamp to the profile limit
	assign speed_eff = (move_setpoint_speed_q > profile_speed_limit) ?
		profile_speed_limit : move_setpoint_speed_q; // [RL15]

	// Target resolution for absolute or relative moves
	always_comb begin
		base_pos = actual_position;
		if (relative_base_option_q == ppc_pkg::REL_BASE_PREV_TARGET) begin
			base_pos = prev_target_q; // [RL13]
		end else if (relative_base_option_q == ppc_pkg::REL_BASE_ACTUAL_POS) begin
			base_pos = actual_position; // [RL13]
		end
		if (drive_control_word_q[ppc_pkg::CTL_RELATIVE]) begin
			tgt_raw = base_pos + move_target_position_q; // [RL3]
		end else begin
			tgt_raw = move_target_position_q; // [RL3]
		end
		tgt_eff = tgt_raw;
		if (software_limit_on && tgt_raw > limit_pos_max) begin
			tgt_eff = limit_pos_max; // [RL16]
		end else if (software_limit_on && tgt_raw < limit_pos_min) begin
			tgt_eff = limit_pos_min; // [RL16]
		end
		cand.target = tgt_eff;
		cand.speed  = speed_eff;
		cand.accel  = accel_ramp_q;
		cand.decel  = decel_ramp_q;
	end

	// Move sequencing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q     <= ppc_pkg::ST_IDLE;
			move_set_q  <= '0;
			move_load_q <= 1'b0;
		end else begin
			move_load_q <= 1'b0;
			case (state_q)
				ppc_pkg::ST_IDLE: begin
					if (start_req) begin
						move_set_q  <= cand;
						move_load_q <= 1'b1;
						state_q     <= ppc_pkg::ST_MOVING;
					end
				end
				ppc_pkg::ST_MOVING, ppc_pkg::ST_PENDING: begin
					if (kill) begin
						state_q <= ppc_pkg::ST_IDLE;
					end else if (start_req && (immediate || move_done)) begin
						// A start that meets the end of the move runs at once
						move_set_q  <= cand; // [RL8]
						move_load_q <= 1'b1;
						state_q     <= ppc_pkg::ST_MOVING;
					end else if (start_req) begin
						state_q <= ppc_pkg::ST_PENDING; // [RL6]
					end else if (move_done && state_q == ppc_pkg::ST_PENDING) begin
						move_set_q  <= pend_q; // [RL6]
						move_load_q <= 1'b1;
						state_q     <= ppc_pkg::ST_MOVING;
					end else if (move_done) begin
						state_q <= ppc_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= ppc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Buffered set, newest start wins while a move runs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pend_q <= '0;
		end else if (start_req && !kill && !immediate && !move_done
			&& state_q != ppc_pkg::ST_IDLE) begin
			pend_q <= cand; // [RL6] [RL7]
		end
	end

	// Previous accepted target, base for relative moves
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_target_q <= ppc_pkg::RST_TARGET_POSITION;
		end else if (start_req && !kill) begin
			prev_target_q <= cand.target; // [RL13]
		end
	end

	// Setpoint acknowledge follows the accepted target
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else if (start_req) begin
			ack_q <= 1'b1; // [RL9]
		end else if (!drive_control_word_q[ppc_pkg::CTL_NEW_SETPOINT]
			&& state_q != ppc_pkg::ST_PENDING) begin
			ack_q <= 1'b0; // [RL9]
		end
	end

	// Completion, reached and error flags
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			end_q     <= 1'b1;
			reached_q <= 1'b0;
			err_q     <= 1'b0;
		end else begin
			if (move_fault) begin
				err_q <= 1'b1; // [RL10]
			end else if (start_req) begin
				err_q <= 1'b0;
			end
			if (kill) begin
				end_q     <= 1'b1; // [RL10]
				reached_q <= 1'b0; // [RL11]
			end else if (state_q == ppc_pkg::ST_MOVING && move_done && !start_req) begin
				end_q     <= 1'b1; // [RL10]
				reached_q <= 1'b1; // [RL11]
			end else if (start_req) begin
				end_q     <= 1'b0;
				reached_q <= 1'b0;
			end
		end
	end

	// Status word assembly
	always_comb begin
		drive_status_word = 16'h0000;
		drive_status_word[ppc_pkg::STS_TARGET_REACHED] = reached_q; // [RL11]
		drive_status_word[ppc_pkg::STS_SETPOINT_ACK]   = ack_q; // [RL9]
		drive_status_word[ppc_pkg::STS_ERROR]          = err_q; // [RL10]
		drive_status_word[ppc_pkg::STS_MOVE_END]       = end_q; // [RL10]
		drive_status_word[ppc_pkg::STS_REF_OK]         = homed; // [RL12]
	end

	// Registered read data
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			case (reg_addr)
				ppc_pkg::ADDR_HOMING_REQUIRED: reg_rdata <= {16'h0000, homing_required_option_q};
				ppc_pkg::ADDR_RELATIVE_BASE:   reg_rdata <= {16'h0000, relative_base_option_q};
				ppc_pkg::ADDR_TARGET_POSITION: reg_rdata <= move_target_position_q;
				ppc_pkg::ADDR_SETPOINT_SPEED:  reg_rdata <= move_setpoint_speed_q;
				ppc_pkg::ADDR_ACCEL_RAMP:      reg_rdata <= accel_ramp_q;
				ppc_pkg::ADDR_DECEL_RAMP:      reg_rdata <= decel_ramp_q;
				ppc_pkg::ADDR_CONTROL_WORD:    reg_rdata <= {16'h0000, drive_control_word_q};
				ppc_pkg::ADDR_STATUS_WORD:     reg_rdata <= {16'h0000, drive_status_word};
				default:                       reg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	assign move_set  = move_set_q;
	assign move_load = move_load_q;

endmodule : ppc_profile_position

// *** hdl/ppc_pkg.sv ***
// Package for the profile-position command block: offsets, layouts, resets.
// Assumes a single control clock domain; register access is a plain word port.
package ppc_pkg;

	// Parameter addresses
	localparam logic [15:0] ADDR_HOMING_REQUIRED = 16'h062c;
	localparam logic [15:0] ADDR_TARGET_POSITION = 16'h1b1c;
	localparam logic [15:0] ADDR_SETPOINT_SPEED  = 16'h1b1e;
	localparam logic [15:0] ADDR_RELATIVE_BASE   = 16'h1b30;
	localparam logic [15:0] ADDR_ACCEL_RAMP      = 16'h1b40;
	localparam logic [15:0] ADDR_DECEL_RAMP      = 16'h1b42;
	localparam logic [15:0] ADDR_CONTROL_WORD    = 16'h1b50;
	localparam logic [15:0] ADDR_STATUS_WORD     = 16'h1b52;

	// Reset values and minimum setpoint speed
	localparam logic [15:0] RST_HOMING_REQUIRED = 16'h0000;
	localparam logic [31:0] RST_TARGET_POSITION = 32'h0000_0000;
	localparam logic [31:0] RST_SETPOINT_SPEED  = 32'h0000_003c;
	localparam logic [15:0] RST_RELATIVE_BASE   = 16'h0002;
	localparam logic [15:0] RST_CONTROL_WORD    = 16'h0000;
	localparam logic [31:0] RST_ACCEL_RAMP      = 32'h0000_0258;
	localparam logic [31:0] RST_DECEL_RAMP      = 32'h0000_0258;
	localparam logic [31:0] MIN_SETPOINT_SPEED  = 32'h0000_0001;

	// Relative base encodings
	localparam logic [15:0] REL_BASE_PREV_TARGET = 16'h0000;
	localparam logic [15:0] REL_BASE_ACTUAL_POS  = 16'h0002;

	// Control word fields
	localparam int CTL_NEW_SETPOINT = 4;
	localparam int CTL_IMMEDIATE    = 5;
	localparam int CTL_RELATIVE     = 6;

	// Status word fields
	localparam int STS_TARGET_REACHED = 10;
	localparam int STS_SETPOINT_ACK   = 12;
	localparam int STS_ERROR          = 13;
	localparam int STS_MOVE_END       = 14;
	localparam int STS_REF_OK         = 15;

	// One parameter set handed to the trajectory generator
	typedef struct packed {
		logic signed [31:0] target;
		logic [31:0]        speed;
		logic [31:0]        accel;
		logic [31:0]        decel;
	} ppc_set_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_MOVING  = 3'b010,
		ST_PENDING = 3'b100
	} ppc_state_t;

endpackage : ppc_pkg

// *** hdl/ppc_edge_detect.sv ***
// Rising-edge detector for the start request.
// Assumes the input is already synchronous to clk.
`timescale 1ns/10ps
module ppc_edge_detect (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Level in, pulse out
	input  wire logic level,
	output logic      rise
);
	logic level_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			level_q <= 1'b0;
		end else begin
			level_q <= level;
		end
	end

	assign rise = level & ~level_q; // [RL18]

endmodule : ppc_edge_detect

// *** sim/ppc_traj_model.sv ***
// Trajectory generator model: ends each loaded move after dly cycles.
// Assumes move_load is a one-cycle pulse; mode picks done, halt or fault.
`timescale 1ns/10ps
module ppc_traj_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Design side
	input  wire logic       move_load,
	output logic            move_done,
	output logic            move_halted,
	output logic            move_fault,
	// Bench control
	input  wire logic [1:0] mode,
	input  wire logic [7:0] dly
);
	logic [7:0] cnt_q;
	logic       run_q;
	logic       end_w;

	always_ff @(posedge clk) begin
		if (!rst_n || move_load) begin
			cnt_q <= dly;
			run_q <= move_load;
		end else if (run_q) begin
			cnt_q <= cnt_q - 8'h01;
			run_q <= cnt_q != 8'h00;
		end
	end
	assign end_w       = run_q && cnt_q == 8'h00;
	assign move_done   = end_w && mode == 2'h0;
	assign move_halted = end_w && mode == 2'h1;
	assign move_fault  = end_w && mode == 2'h2;
endmodule : ppc_traj_model

// *** sim/ppc_pp_chk.sv ***
// Checker for the profile-position block: load timing, status, clamps.
// Assumes the speed limit is held steady around each load.
`timescale 1ns/10ps
module ppc_pp_chk (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Parameter port
	input  wire logic              reg_wr,
	input  wire logic [15:0]       reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic [31:0]       reg_rdata,
	// Drive state
	input  wire logic              op_enabled,
	input  wire logic              homed,
	input  wire logic [31:0]       profile_speed_limit,
	// Trajectory side
	input  wire ppc_pkg::ppc_set_t move_set,
	input  wire logic              move_load
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic c4_q;
	logic ctl_wr;
	logic rd_sts;

	assign ctl_wr = reg_wr && reg_addr == ppc_pkg::ADDR_CONTROL_WORD;
	assign rd_sts = reg_addr == ppc_pkg::ADDR_STATUS_WORD;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			c4_q <= 1'b0;
		end else if (ctl_wr) begin
			c4_q <= reg_wdata[4];
		end
	end

	load_once_a: assert property (move_load |=> !move_load)
		else $error("load pulse too long");
	no_start_off_a: assert property ((!op_enabled)[*3] |-> !move_load)
		else $error("load while not enabled");
	imm_load_a: assert property ((ctl_wr && reg_wdata[5:4] == 2'h3 && !c4_q && op_enabled
		&& (reg_wdata[6] || homed) ##1 op_enabled) |=> move_load)
		else $error("immediate start not loaded");
	ack_set_a: assert property ((move_load && rd_sts) ##1 rd_sts
		|-> reg_rdata[12] && !reg_rdata[14])
		else $error("ack or end wrong at load");
	ref_flag_a: assert property (rd_sts && $past(rd_sts) && $past(rst_n)
		&& $past(homed) == homed && $past(homed, 2) == homed |-> reg_rdata[15] == homed)
		else $error("reference flag wrong");
	speed_clamp_a: assert property (move_load
		|-> move_set.speed <= profile_speed_limit && move_set.speed != 32'h0)
		else $error("speed not clamped");
	set_hold_a: assert property (!move_load |-> $stable(move_set))
		else $error("set changed without load");
	unmapped_zero_a: assert property ($past(reg_addr) < 16'h0600 && $past(rst_n)
		|-> reg_rdata == 32'h0)
		else $error("unmapped read not zero");

	cover property (move_load);
	cover property (ctl_wr && reg_wdata[5:4] == 2'h1 && c4_q == 1'b0);
	cover property (rd_sts && reg_rdata[13]);
endmodule : ppc_pp_chk

// *** sim/tb.sv ***
// Bench for the profile-position block: table, starts, endings, reset.
// Assumes the trajectory model ends each move after dly cycles.
`timescale 1ns/10ps
module tb;
	typedef struct packed {
		logic        w;
		logic [15:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} ppc_row_t;
	logic               clk, rst_n, reg_wr, op_en, homed, st_in, soft_on;
	logic               done, halted, fault, move_load;
	logic [1:0]         mode;
	logic [7:0]         dly;
	logic [15:0]        reg_addr;
	logic [31:0]        reg_wdata, reg_rdata, q;
	logic signed [31:0] act_pos;
	ppc_pkg::ppc_set_t  move_set;
	int                 bad_count, n_checks, loads, base;
	ppc_row_t           rows [12] = '{'{1'b0, 16'h062c, 32'h0, 32'h0},
		'{1'b0, 16'h1b1c, 32'h0, 32'h0}, '{1'b0, 16'h1b1e, 32'h0, 32'h3c},
		'{1'b0, 16'h1b30, 32'h0, 32'h2}, '{1'b0, 16'h1b40, 32'h0, 32'h258},
		'{1'b0, 16'h1b42, 32'h0, 32'h258},
		'{1'b0, 16'h0100, 32'h0, 32'h0}, '{1'b0, 16'h1b52, 32'h0, 32'h4000},
		'{1'b1, 16'h1b1e, 32'h0, 32'h3c}, '{1'b1, 16'h1b1e, 32'h1, 32'h1},
		'{1'b1, 16'h1b1c, 32'hffff_fff0, 32'hffff_fff0}, '{1'b1, 16'h1b30, 32'h0, 32'h0}};

	ppc_profile_position dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .op_enabled(op_en), .homed(homed),
		.start_input(st_in), .software_limit_on(soft_on), .limit_pos_max(32'h3e8),
		.limit_pos_min(32'hffff_fc18), .profile_speed_limit(32'h3e8), .actual_position(act_pos),
		.move_done(done), .move_halted(halted), .move_fault(fault), .move_set(move_set),
		.move_load(move_load));
	ppc_traj_model u_traj (.clk(clk), .rst_n(rst_n), .move_load(move_load), .move_done(done),
		.move_halted(halted), .move_fault(fault), .mode(mode), .dly(dly));

	always @(posedge clk) if (move_load === 1'b1) loads++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ppc_pkg::ADDR_STATUS_WORD;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		q = reg_rdata;
	endtask : rd
	task automatic sts(input logic [31:0] m, input logic [31:0] e);
		rd(ppc_pkg::ADDR_STATUS_WORD);
		chk(q & m, e);
	endtask : sts
	task automatic start(input logic [31:0] c);
		wr(ppc_pkg::ADDR_CONTROL_WORD, 32'h0);
		wr(ppc_pkg::ADDR_CONTROL_WORD, c);
		repeat (3) @(negedge clk);
	endtask : start
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (4000) @(posedge clk);
		bad_count++;
		end_of_test();
	end
	initial begin
		{reg_wr, op_en, homed, st_in, soft_on, reg_wdata, mode} = '0;
		{rst_n, reg_addr, act_pos, dly} = {1'b0, 16'h1b52, 32'h64, 8'h14};
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk(q, rows[i].e);
		end
		$display("table done");
		start(32'h50);
		chk(32'(loads), 32'h0);
		sts(32'h1000, 32'h0);
		op_en = 1'b1;
		wr(16'h062c, 32'h1);
		wr(16'h1b1c, 32'h1f4);
		start(32'h10);
		chk(32'(loads), 32'h0);
		homed = 1'b1;
		start(32'h10);
		chk(32'(loads), 32'h1);
		chk(move_set.target, 32'h1f4);
		sts(32'hf400, 32'h9000);
		repeat (25) @(negedge clk);
		sts(32'he400, 32'hc400);
		$display("start done");
		wr(16'h1b1e, 32'h7d0);
		wr(16'h1b1c, 32'h5);
		for (int i = 0; i < 3; i++) begin
			wr(16'h1b30, 32'(2 - i));
			start(32'h50);
			chk(move_set.target, i < 2 ? 32'h69 : 32'h6e);
			repeat (25) @(negedge clk);
		end
		chk(move_set.speed, 32'h3e8);
		soft_on = 1'b1;
		wr(16'h1b1c, 32'h1388);
		start(32'h10);
		chk(move_set.target, 32'h3e8);
		soft_on = 1'b0;
		repeat (25) @(negedge clk);
		$display("relative done");
		dly = 8'h28;
		wr(16'h1b1c, 32'h10);
		start(32'h10);
		base = loads;
		wr(16'h1b1c, 32'h20);
		start(32'h10);
		wr(16'h1b1c, 32'h30);
		wr(16'h1b40, 32'h64);
		start(32'h10);
		chk(32'(loads), 32'(base));
		repeat (40) @(negedge clk);
		chk(32'(loads), 32'(base + 1));
		chk(move_set.target, 32'h30);
		chk(move_set.accel, 32'h64);
		chk(move_set.decel, 32'h258);
		wr(16'h1b1c, 32'h40);
		start(32'h30);
		chk(32'(loads), 32'(base + 2));
		chk(move_set.target, 32'h40);
		dly = 8'h14;
		repeat (50) @(negedge clk);
		$display("buffer done");
		for (int m = 1; m < 3; m++) begin
			mode = 2'(m);
			start(32'h10);
			repeat (25) @(negedge clk);
			sts(32'he400, m == 1 ? 32'hc000 : 32'he000);
		end
		$display("ending done");
		mode = 2'h0;
		base = loads;
		wr(ppc_pkg::ADDR_CONTROL_WORD, 32'h10);
		repeat (3) @(negedge clk);
		chk(32'(loads), 32'(base));
		st_in = 1'b1;
		repeat (3) @(negedge clk);
		chk(32'(loads), 32'(base + 1));
		st_in = 1'b0;
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk(move_set.target, 32'h0);
		rd(16'h1b30);
		chk(q, 32'h2);
		$display("reset done");
		end_of_test();
	end
endmodule : tb

bind ppc_profile_position ppc_pp_chk u_chk (.clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata,
	.reg_rdata, .op_enabled, .homed, .profile_speed_limit, .move_set, .move_load);
